/* inc/evp_consts.svh */
// Purpose: Constants for exception vectoring and priority resolution
// Assumes: Exception number is vector number; IRQ n is exception 16+n
// Notes: Offsets in bytes, ranks are internal priority encodings
`ifndef EVP_CONSTS_SVH
`define EVP_CONSTS_SVH

`define EVP_NUM_IRQ 55
`define EVP_IRQ_BASE 16
`define EVP_EXC_RESET 1
`define EVP_EXC_NMI 2
`define EVP_EXC_HARD_FAULT 3
`define EVP_SYS_IMPL_MASK 16'hd87c
`define EVP_IRQ_RSVD_MASK 64'h007f_f660_0000_3e00
`define EVP_BASE_RESET 32'h0000_0000
`define EVP_BASE_MIN 32'h0000_0100
`define EVP_BASE_MAX 32'h3fff_ff00
`define EVP_BASE_ALIGN_MASK 32'hffff_ff00
`define EVP_PRIO_RESET 3'h0
`define EVP_RANK_RESET 4'h0
`define EVP_RANK_NMI 4'h1
`define EVP_RANK_HARD_FAULT 4'h2
`define EVP_RANK_CFG_BASE 4'h3
`define EVP_RANK_IDLE 4'hf

`endif

/* inc/evp_pkg.sv */
// Purpose: Types for exception vectoring and priority resolution
// Assumes: At most 128 exception numbers
// Notes: Carried as packed structs between core and block
package evp_pkg;

  typedef logic [6:0] evp_num_t;
  typedef logic [2:0] evp_prio_t;
  typedef logic [3:0] evp_rank_t;

  typedef struct packed {
    logic en;
    evp_num_t num;
    evp_prio_t val;
  } evp_prio_wr_t;

  typedef struct packed {
    logic en;
    logic [31:0] data;
  } evp_base_wr_t;

  typedef struct packed {
    logic en;
    evp_num_t num;
  } evp_ret_t;

  typedef struct packed {
    logic valid;
    evp_num_t num;
    logic [31:0] addr;
  } evp_take_t;

endpackage : evp_pkg

/* rtl/evp_top.sv */
// Purpose: Exception pending/active tracking, priority arbitration, vector address
// Assumes: Requests and core signals come from logic on clk_sys
// Notes: Take offer is registered and reflects state after this cycle's updates
//
// Operation
// - Each exception has fixed vector offset; IRQs start at vector 16, offset 0x40.
// - IRQ number is vector minus sixteen; listed reserved numbers never pend.
// - Stack pointer fetched from table entry 0, handlers from their own entry.
// - After reset the table base is zero.
// - Privileged writes relocate the base within 0x100 to 0x3fffff00.
// - Lower priority value is more urgent.
// - Reset, hard fault and NMI priorities cannot be configured.
// - Configurable priorities reset to zero.
// - Configurable priorities are 0-7, below all fixed negative priorities.
// - Equal priority ties go to lowest exception number.
// - Running handler is preempted by strictly higher priority pending exception.
// - Equal priority arrival does not preempt; it stays pending.
// - Each exception is inactive, pending, active, or active and pending.
// - NMI has fixed priority -2, always enabled, preempted only by reset.
// - Hard fault has fixed priority -1, above all configurable ones.
`include "evp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module evp_top #(
  parameter int NUM_IRQ = `EVP_NUM_IRQ
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] sys_req,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic priv,
  input wire evp_pkg::evp_prio_wr_t prio_wr,
  input wire evp_pkg::evp_base_wr_t base_wr,
  input wire logic take_ack,
  input wire evp_pkg::evp_ret_t ret,
  output var evp_pkg::evp_take_t take,
  output logic [31:0] sp_fetch_addr,
  output logic [31:0] vector_base,
  output logic [`EVP_IRQ_BASE+NUM_IRQ-1:0] exc_pending,
  output logic [`EVP_IRQ_BASE+NUM_IRQ-1:0] exc_active
);

  localparam int N = `EVP_IRQ_BASE + NUM_IRQ;

  logic [N-1:0] pending_reg;
  logic [N-1:0] pending_next;
  logic [N-1:0] active_reg;
  logic [N-1:0] active_next;
  evp_pkg::evp_prio_t prio_reg [N];
  evp_pkg::evp_prio_t prio_next [N];
  logic [31:0] vector_base_offset_reg;
  logic [31:0] vector_base_offset_next;
  evp_pkg::evp_take_t take_reg;
  evp_pkg::evp_take_t take_next;
  logic [N-1:0] req_vec;
  evp_pkg::evp_rank_t run_rank;
  evp_pkg::evp_rank_t best_rank;
  evp_pkg::evp_num_t best_num;
  logic best_found;
  wire logic [N-1:0] impl_vec;
  wire logic [N-1:0] cfg_vec;
  wire logic [N-1:0] set_vec;
  wire evp_pkg::evp_rank_t rank_vec [N];

  // Exception numbers that exist and can pend
  function automatic logic is_impl(input int n);
    logic [63:0] rsvd;
    logic [15:0] sys;
    rsvd = `EVP_IRQ_RSVD_MASK;
    sys = `EVP_SYS_IMPL_MASK;
    if (n < `EVP_IRQ_BASE) begin
      is_impl = sys[n];
    end else if (n < N) begin
      is_impl = (n - `EVP_IRQ_BASE >= 64) || !rsvd[n-`EVP_IRQ_BASE];
    end else begin
      is_impl = 1'b0;
    end
  endfunction : is_impl

  function automatic logic is_fixed(input int n);
    is_fixed = (n == `EVP_EXC_RESET) || (n == `EVP_EXC_NMI) || (n == `EVP_EXC_HARD_FAULT);
  endfunction : is_fixed

  // Urgency rank; lower is more urgent
  function automatic evp_pkg::evp_rank_t rank_of(input int n, input evp_pkg::evp_prio_t p);
    if (n == `EVP_EXC_RESET) begin
      rank_of = `EVP_RANK_RESET;
    end else if (n == `EVP_EXC_NMI) begin
      rank_of = `EVP_RANK_NMI;
    end else if (n == `EVP_EXC_HARD_FAULT) begin
      rank_of = `EVP_RANK_HARD_FAULT;
    end else begin
      rank_of = `EVP_RANK_CFG_BASE + {1'b0, p};
    end
  endfunction : rank_of

  function automatic logic outranks(input evp_pkg::evp_rank_t a, input evp_pkg::evp_rank_t b);
    outranks = a < b;
  endfunction : outranks

  // Per-exception decode
  for (genvar g = 0; g < N; g++) begin : g_exc
    assign impl_vec[g] = is_impl(g);
    assign cfg_vec[g] = impl_vec[g] && !is_fixed(g);
    assign set_vec[g] = req_vec[g] && impl_vec[g];
    assign rank_vec[g] = rank_of(g, prio_next[g]);
  end : g_exc

  // Request vector by exception number
  always_comb begin
    req_vec = '0;
    req_vec[15:0] = sys_req;
    req_vec[N-1:`EVP_IRQ_BASE] = irq_req;
  end

  // Pending and active state
  always_comb begin
    pending_next = pending_reg;
    active_next = active_reg;
    if (take_ack && take_reg.valid) begin
      pending_next[take_reg.num] = 1'b0;
      active_next[take_reg.num] = 1'b1;
    end
    if (ret.en && (int'(ret.num) < N)) begin
      if (!(take_ack && take_reg.valid && take_reg.num == ret.num)) begin
        active_next[ret.num] = 1'b0;
      end
    end
    pending_next = pending_next | set_vec;
  end

  // Priority configuration
  always_comb begin
    for (int n = 0; n < N; n++) begin
      prio_next[n] = prio_reg[n];
    end
    if (prio_wr.en && priv && (int'(prio_wr.num) < N)) begin
      if (cfg_vec[prio_wr.num]) begin
        prio_next[prio_wr.num] = prio_wr.val;
      end
    end
  end

  // Table base relocation
  always_comb begin
    vector_base_offset_next = vector_base_offset_reg;
    if (base_wr.en && priv && (base_wr.data >= `EVP_BASE_MIN) && (base_wr.data <= `EVP_BASE_MAX)) begin
      vector_base_offset_next = base_wr.data & `EVP_BASE_ALIGN_MASK;
    end
  end

  // Arbitration on the updated state
  always_comb begin
    run_rank = `EVP_RANK_IDLE;
    best_rank = `EVP_RANK_IDLE;
    best_num = '0;
    best_found = 1'b0;
    for (int n = 0; n < N; n++) begin
      if (active_next[n] && outranks(rank_vec[n], run_rank)) begin
        run_rank = rank_vec[n];
      end
    end
    for (int n = 0; n < N; n++) begin
      if (pending_next[n] && (!best_found || outranks(rank_vec[n], best_rank))) begin
        best_rank = rank_vec[n];
        best_num = evp_pkg::evp_num_t'(n);
        best_found = 1'b1;
      end
    end
    take_next.valid = best_found && outranks(best_rank, run_rank);
    take_next.num = best_num;
    take_next.addr = vector_base_offset_next + {23'h0, best_num, 2'b00};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pending_reg <= '0;
      active_reg <= '0;
    end else begin
      pending_reg <= pending_next;
      active_reg <= active_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int n = 0; n < N; n++) begin
        prio_reg[n] <= `EVP_PRIO_RESET;
      end
    end else begin
      for (int n = 0; n < N; n++) begin
        prio_reg[n] <= prio_next[n];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vector_base_offset_reg <= `EVP_BASE_RESET;
    end else begin
      vector_base_offset_reg <= vector_base_offset_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      take_reg <= '0;
    end else begin
      take_reg <= take_next;
    end
  end

  assign take = take_reg;
  assign sp_fetch_addr = vector_base_offset_reg;
  assign vector_base = vector_base_offset_reg;
  assign exc_pending = pending_reg;
  assign exc_active = active_reg;

endmodule : evp_top

`default_nettype wire

/* tb/evp_core_model.sv */
// Purpose: Core side model that takes offers and ends handlers
// Assumes: Acts on falling clk_sys edge
// Notes: Ends the innermost handler first
`timescale 1ns/1ps
`default_nettype none
module evp_core_model (
  input wire logic clk_sys,
  input wire logic ack_en,
  input wire logic ret_go,
  input wire evp_pkg::evp_take_t take,
  output logic take_ack,
  output var evp_pkg::evp_ret_t ret
);
  evp_pkg::evp_num_t stk[$];
  logic [31:0] vtab [128];
  logic [31:0] handler;
  initial begin
    take_ack = 1'b0;
    ret = '0;
    handler = '0;
    for (int k = 0; k < 128; k++) begin
      vtab[k] = 32'h0000_1000 + 32'(k * 32) + 32'h1;
    end
  end
  always @(negedge clk_sys) begin
    take_ack <= ack_en && take.valid;
    ret.en <= 1'b0;
    if (ack_en && take.valid) begin
      stk.push_back(take.num);
      handler <= vtab[take.num];
    end else if (ret_go && stk.size() > 0) begin
      ret.en <= 1'b1;
      ret.num <= stk.pop_back();
    end
  end
endmodule : evp_core_model
`default_nettype wire

/* tb/evp_checker.sv */
// Purpose: Port checker for evp_top
// Assumes: Bound into evp_top
// Notes: Sees design ports only
`include "evp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module evp_checker #(parameter int NUM_IRQ = 55) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic priv,
  input wire evp_pkg::evp_base_wr_t base_wr,
  input wire logic take_ack,
  input wire evp_pkg::evp_take_t take,
  input wire logic [31:0] sp_fetch_addr,
  input wire logic [31:0] vector_base,
  input wire logic [NUM_IRQ+15:0] exc_pending,
  input wire logic [NUM_IRQ+15:0] exc_active
);
  localparam logic [63:0] IRQ_RSVD = `EVP_IRQ_RSVD_MASK;
  localparam logic [15:0] SYS_IMPL = `EVP_SYS_IMPL_MASK;
  localparam logic [NUM_IRQ+15:0] UNUSED = {IRQ_RSVD[NUM_IRQ-1:0], ~SYS_IMPL};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_entry;
    take.valid && take_ack;
  endsequence
  base_reset_a: assert property (disable iff (1'b0) rst |=> vector_base == 32'h0) else $error("base reset");
  sp_entry_a: assert property (sp_fetch_addr == vector_base) else $error("sp entry");
  vec_addr_a: assert property (take.valid |-> take.addr == vector_base + {23'h0, take.num, 2'h0}) else $error("addr");
  relocate_a: assert property (base_wr.en && priv && base_wr.data[7:0] == 8'h0 && base_wr.data >= `EVP_BASE_MIN
    && base_wr.data <= `EVP_BASE_MAX |=> vector_base == $past(base_wr.data)) else $error("relocate");
  reserved_a: assert property ((exc_pending & UNUSED) == '0) else $error("reserved pend");
  nmi_first_a: assert property (exc_pending[2] && !exc_active[2] |-> take.valid && take.num == 7'h2) else $error("nmi");
  hard_fault_a: assert property (exc_pending[3] && !exc_pending[2] && exc_active[3:2] == 2'h0
    |-> take.valid && take.num == 7'h3) else $error("hard fault");
  entry_active_a: assert property (s_entry |=> exc_active[$past(take.num)]) else $error("active");
  base_hold_a: assert property (!(base_wr.en && priv) |=> $stable(vector_base)) else $error("base moved");
  offer_state_a: assert property (take.valid |-> exc_pending[take.num]
    && !exc_active[take.num]) else $error("offer state");
endmodule : evp_checker
bind evp_top evp_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.clk_sys(clk_sys), .rst(rst), .priv(priv), .base_wr(base_wr),
  .take_ack(take_ack), .take(take), .sp_fetch_addr(sp_fetch_addr), .vector_base(vector_base),
  .exc_pending(exc_pending), .exc_active(exc_active));
`default_nettype wire

/* tb/exception_vector_priority_bench.sv */
// Purpose: Self-checking bench for evp_top
// Assumes: Inputs change on falling edge
// Notes: Entries are compared in order
`timescale 1ns/1ps
`default_nettype none
module exception_vector_priority_bench;
  logic clk_sys, rst, priv, ack_en, ret_go, take_ack;
  logic [15:0] sys_req;
  logic [54:0] irq_req;
  logic [31:0] sp_fetch_addr, vector_base, exp_base;
  logic [70:0] exc_pending, exc_active;
  logic [38:0] expq[$];
  evp_pkg::evp_prio_wr_t prio_wr;
  evp_pkg::evp_base_wr_t base_wr;
  evp_pkg::evp_ret_t ret;
  evp_pkg::evp_take_t take;
  int n_fail, num_checks, seed, i;
  evp_top dut (.clk_sys(clk_sys), .rst(rst), .sys_req(sys_req), .irq_req(irq_req), .priv(priv), .prio_wr(prio_wr),
    .base_wr(base_wr), .take_ack(take_ack), .ret(ret), .take(take), .sp_fetch_addr(sp_fetch_addr),
    .vector_base(vector_base), .exc_pending(exc_pending), .exc_active(exc_active));
  evp_core_model core (.clk_sys(clk_sys), .ack_en(ack_en), .ret_go(ret_go), .take(take), .take_ack(take_ack), .ret(ret));
  task chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task want(input int n);
    expq.push_back({n[6:0], exp_base + 32'(4 * n)});
  endtask : want
  task pulse(input logic [70:0] req);
    @(negedge clk_sys);
    {irq_req, sys_req} = req;
    @(negedge clk_sys);
    {irq_req, sys_req} = '0;
  endtask : pulse
  task wr(input logic pv, input logic isb, input logic [31:0] d, input logic [6:0] n);
    @(negedge clk_sys);
    priv = pv;
    prio_wr = {!isb, n, d[2:0]};
    base_wr = {isb, d};
    @(negedge clk_sys);
    prio_wr = '0;
    base_wr = '0;
  endtask : wr
  task drain;
    for (i = 0; i < 40 && expq.size() > 0; i++) @(negedge clk_sys);
    chk(expq.size() == 0, "entry missing");
    expq.delete();
    repeat (4) @(negedge clk_sys);
  endtask : drain
  always @(posedge clk_sys) if (take.valid === 1'b1 && take_ack === 1'b1) begin
    if (expq.size() == 0) chk(1'b0, "extra entry");
    else chk({take.num, take.addr} === expq.pop_front(), "entry");
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end
  initial begin
    {seed, n_fail, num_checks, rst, priv, ack_en, ret_go} = {32'd30, 64'd0, 4'b1011};
    {sys_req, irq_req, prio_wr, base_wr, exp_base} = '0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    chk(vector_base === 32'h0 && exc_pending === '0, "reset");
    for (int k = 0; k < 6; k++) begin
      i = $unsigned($random(seed)) % 9;
      want(16 + i);
      pulse(71'h1 << (16 + i));
      drain();
    end
    want(16);
    want(17);
    pulse(71'h3 << 16);
    drain();
    wr(1'b1, 1'b0, 32'h5, 7'h10);
    wr(1'b1, 1'b0, 32'h2, 7'h11);
    wr(1'b1, 1'b0, 32'h7, 7'h3);
    want(17);
    want(16);
    pulse(71'h3 << 16);
    drain();
    want(2);
    want(3);
    want(16);
    pulse(71'h1000c);
    drain();
    wr(1'b1, 1'b0, 32'h2, 7'h12);
    ret_go <= 1'b0;
    want(16);
    pulse(71'h1 << 16);
    drain();
    want(17);
    pulse(71'h1 << 17);
    drain();
    pulse(71'h1 << 18);
    chk(exc_pending[18] && !exc_active[18] && !take.valid, "equal preempted");
    want(18);
    ret_go <= 1'b1;
    drain();
    wr(1'b1, 1'b1, 32'h100, 7'h0);
    wr(1'b0, 1'b1, 32'h200, 7'h0);
    wr(1'b1, 1'b1, 32'h4000_0000, 7'h0);
    exp_base = 32'h100;
    chk(vector_base === 32'h100 && sp_fetch_addr === 32'h100, "relocate");
    want(18);
    pulse(71'h1 << 18);
    drain();
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(vector_base === 32'h0, "base after reset");
    print_verdict();
  end
endmodule : exception_vector_priority_bench
`default_nettype wire
